// *** cmcs_link_if.sv ***
// word and settings carrier between the link receiver and the core
`timescale 1ns/100ps
interface cmcs_link_if;
    import cmcs_pkg::*;
    logic rx_enable;
    cmcs_mode_t mode;
    logic [1:0] width_sel;
    logic [31:0] word;
    logic word_toggle;

    modport rx (input rx_enable, input mode, input width_sel,
                output word, output word_toggle);
    modport core (output rx_enable, output mode, output width_sel,
                  input word, input word_toggle);
endinterface

// *** cmcs_link_rx.sv ***
// slave-mode receiver running on the externally supplied configuration clock
`timescale 1ns/100ps
module cmcs_link_rx
    import cmcs_pkg::*;
(
    // link clock and reset
    input logic link_clock,
    input logic rst,
    // slave pins, synchronous to the link clock
    input logic [15:0] data_in,
    input logic chip_select_n,
    input logic read_write_n,
    // towards the core
    cmcs_link_if.rx lk
);

    logic en_s1_reg, en_s2_reg;
    cmcs_mode_t mode_s1_reg, mode_s2_reg;
    logic [1:0] wsel_s1_reg, wsel_s2_reg;
    logic [31:0] acc_reg, word_reg;
    logic [5:0] cnt_reg;
    logic toggle_reg;
    logic take;
    logic [5:0] bits;

    // settings are static during a load, so level synchronisers suffice
    always_ff @(posedge link_clock or posedge rst)
    begin
        if (rst)
        begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            mode_s1_reg <= MODE_MASTER_SERIAL;
            mode_s2_reg <= MODE_MASTER_SERIAL;
            wsel_s1_reg <= 2'h0;
            wsel_s2_reg <= 2'h0;
        end
        else
        begin
            en_s1_reg <= lk.rx_enable;
            en_s2_reg <= en_s1_reg;
            mode_s1_reg <= lk.mode;
            mode_s2_reg <= mode_s1_reg;
            wsel_s1_reg <= lk.width_sel;
            wsel_s2_reg <= wsel_s1_reg;
        end
    end

    // serial takes every edge; parallel only while selected and writing
    always_comb
    begin
        bits = bits_per_edge(mode_s2_reg, wsel_s2_reg);
        take = 1'b0;
        if (en_s2_reg && mode_s2_reg == MODE_SLAVE_SERIAL)
            take = 1'b1;
        if (en_s2_reg && mode_s2_reg == MODE_SLAVE_PARALLEL)
            take = !chip_select_n && !read_write_n;
    end

    always_ff @(posedge link_clock or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= 32'h0;
            cnt_reg <= 6'h00;
            word_reg <= 32'h0;
            toggle_reg <= 1'b0;
        end
        else if (!en_s2_reg)
            cnt_reg <= 6'h00;
        else if (take)
        begin
            acc_reg <= shift_in(acc_reg, data_in, bits);
            if (cnt_reg + bits >= 6'(WORD_BITS))
            begin
                cnt_reg <= 6'h00;
                word_reg <= shift_in(acc_reg, data_in, bits);
                toggle_reg <= ~toggle_reg;
            end
            else
                cnt_reg <= cnt_reg + bits;
        end
    end

    assign lk.word = word_reg;
    assign lk.word_toggle = toggle_reg;

    property p_rx_idle_parallel;
        @(posedge link_clock) disable iff (rst)
        (mode_s2_reg == MODE_SLAVE_PARALLEL && chip_select_n)
            |=> $stable(cnt_reg) && $stable(acc_reg);
    endproperty
    a_rx_idle_parallel: assert property (p_rx_idle_parallel)
        else $error("parallel port took data while deselected");

endmodule

// *** cmcs_loader_model.sv ***
// external loader driving the parallel slave pins on its own clock
`timescale 1ns/100ps
module cmcs_loader_model (
    // request from the bench
    input wire logic go,
    input wire logic [31:0] word,
    // parallel slave pins
    output logic link_clock,
    output logic [15:0] data,
    output logic select_n,
    output logic write_n,
    output logic busy
);
    initial
    begin
        {link_clock, busy, select_n, write_n} = 4'h3;
        data = 16'h5a5a;
    end
    // clock runs only inside a frame; idle cycles let the settings settle
    always @(posedge go)
    begin
        busy = 1'b1;
        #7;
        for (int i = -6; i < 4; i++)
        begin
            select_n = (i < 0);
            write_n = (i < 0);
            if (i >= 0)
                data = {8'h00, word[31 - 8 * i -: 8]};
            #16 link_clock = 1'b1;
            #16 link_clock = 1'b0;
        end
        {select_n, write_n} = 2'h3;
        data = ~data;
        busy = 1'b0;
    end
endmodule

// *** cmcs_pkg.sv ***
// constants, types and helpers for the load-mode and clock-select block
package cmcs_pkg;

    // clock of the register side
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;

    // configuration clock rates, in MHz
    localparam logic [7:0] START_RATE_MHZ = 8'h01;
    localparam logic [7:0] DEFAULT_RATE_MHZ = 8'h02;
    localparam logic [7:0] MAX_RATE_MHZ = 8'h32;

    // mode-pin encodings {hi, lo}
    typedef logic [1:0] cmcs_mode_t;
    localparam cmcs_mode_t MODE_MASTER_SERIAL = 2'h0;
    localparam cmcs_mode_t MODE_MASTER_PARALLEL = 2'h1;
    localparam cmcs_mode_t MODE_SLAVE_PARALLEL = 2'h2;
    localparam cmcs_mode_t MODE_SLAVE_SERIAL = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DONE} cmcs_state_t;

    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_RATE = 4'h8;
    localparam logic [3:0] REG_WORD = 4'hc;

    // control register fields
    localparam int CTRL_EXT_CLK = 0;
    localparam int CTRL_KEEP_PINS = 1;
    localparam int CTRL_UPSET = 2;
    localparam int CTRL_TAP = 3;
    localparam int CTRL_SUSPEND_INT = 4;
    localparam int CTRL_ENCRYPT = 5;
    localparam int CTRL_WIDTH_LO = 6;
    localparam int CTRL_WIDTH_HI = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // status register fields
    localparam int STAT_MODE_LO = 0;
    localparam int STAT_LOAD = 2;
    localparam int STAT_DONE = 3;
    localparam int STAT_OSC = 4;
    localparam int STAT_RATE_SEEN = 5;

    // image word that carries the clock rate setting in its low byte
    localparam logic [15:0] RATE_MARK = 16'ha55a;
    localparam int WORD_BITS = 32;

    function automatic logic is_master(input cmcs_mode_t m);
        return (m == MODE_MASTER_SERIAL) || (m == MODE_MASTER_PARALLEL);
    endfunction

    // bits taken per clock edge for mode and width select
    function automatic logic [5:0] bits_per_edge(input cmcs_mode_t m,
                                                 input logic [1:0] w);
        logic [5:0] b;
        b = 6'h01;
        case (m)
            MODE_MASTER_SERIAL:
                b = (w == 2'h2) ? 6'h04 : ((w == 2'h1) ? 6'h02 : 6'h01);
            MODE_MASTER_PARALLEL, MODE_SLAVE_PARALLEL:
                b = w[0] ? 6'h10 : 6'h08;
            default:
                b = 6'h01;
        endcase
        return b;
    endfunction

    // shift a group of b bits from d into the word accumulator
    function automatic logic [31:0] shift_in(input logic [31:0] acc,
                                             input logic [15:0] d,
                                             input logic [5:0] b);
        logic [31:0] mask;
        mask = (32'h1 << b) - 32'h1;
        return (acc << b) | ({16'h0000, d} & mask);
    endfunction

    // system clocks per half period of the configuration clock
    function automatic logic [15:0] half_count(input logic [7:0] r);
        int rr;
        rr = (r > MAX_RATE_MHZ) ? int'(MAX_RATE_MHZ) : int'(r);
        if (rr == 0)
            rr = int'(DEFAULT_RATE_MHZ);
        return 16'(CLK_MHZ / (2 * rr));
    endfunction

endpackage

// *** cmcs_top.sv ***
// load-mode decode and configuration clock management
// What this block does
// - mode pins pick the load mode
// - master modes drive clock, oscillator or external
// - rate comes from image, default 2 MHz
// - clock starts at 1 MHz until rate arrives
// - oscillator stops after load unless kept
// - suspend clock runs oscillator only during wake
// - no pull-up; clock pin freed unless kept
// - slave modes take clock from outside party
// - boundary-scan path always enabled
// - slave parallel: byte/word, select, direction inputs
// - slave serial: clock plus one data input
// - master serial takes one, two, four bits
// - master serial variants share one encoding
// - master parallel shares encoding, byte or word
// - every power-up needs a full fresh load
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module cmcs_top
    import cmcs_pkg::*;
(
    // system clock and reset
    input logic clock,
    input logic rst,
    // avalon-mm slave
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // mode pins and clock sources
    input logic load_mode_pin_hi,
    input logic load_mode_pin_lo,
    input logic external_master_clock,
    // configuration clock pin
    input logic config_clock_in,
    output logic config_clock_out,
    output logic config_clock_oe,
    // configuration data pins
    input logic [15:0] config_data_in,
    input logic chip_select_n,
    input logic read_write_n,
    // sequencing
    input logic start_config,
    input logic load_complete,
    input logic wake_sequence,
    // status outputs
    output logic osc_enable,
    output logic user_pin_release,
    output logic scan_path_enable,
    output logic config_active
);

    cmcs_link_if lk ();

    cmcs_state_t state_reg, state_next;
    cmcs_mode_t mode_reg;
    logic [1:0] pin_s1_reg, pin_s2_reg;
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic [15:0] dat_s1_reg, dat_s2_reg;
    logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] rate_reg;
    logic rate_seen_reg;
    logic [15:0] half_reg, div_reg;
    logic [31:0] acc_reg, word_reg;
    logic [5:0] cnt_reg;
    logic master_word;
    logic [31:0] master_data;
    logic new_word;
    logic [31:0] new_data;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic clk_out_reg, clk_oe_reg, osc_reg, release_reg, scan_reg;
    logic active_reg;
    logic begin_load, master_run, toggle_now, rise_now, keep_osc;
    logic [5:0] bits;

    // pin synchronisers; first stages feed only second stages
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_reg <= 2'h0;
            pin_s2_reg <= 2'h0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            dat_s1_reg <= 16'h0000;
            dat_s2_reg <= 16'h0000;
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end
        else
        begin
            pin_s1_reg <= {load_mode_pin_hi, load_mode_pin_lo};
            pin_s2_reg <= pin_s1_reg;
            ext_s1_reg <= external_master_clock;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            dat_s1_reg <= config_data_in;
            dat_s2_reg <= dat_s1_reg;
            tog_s1_reg <= lk.word_toggle;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end

    // load sequence; reset always lands in the unconfigured state
    always_comb
    begin
        begin_load = start_config && state_reg != ST_LOAD;
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (begin_load)
                    state_next = ST_LOAD;
            ST_LOAD:
                if (load_complete)
                    state_next = ST_DONE;
            ST_DONE:
                if (begin_load)
                    state_next = ST_LOAD;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // mode captured once per load; the pins may move freely afterwards
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            mode_reg <= MODE_MASTER_SERIAL;
        else if (begin_load)
            mode_reg <= pin_s2_reg;
    end

    // the serial and flash-serial variants share one code, and likewise
    // the two parallel master variants, so no further decode is needed
    assign master_run = state_reg == ST_LOAD && is_master(mode_reg);
    assign bits = bits_per_edge(mode_reg,
                                ctrl_reg[CTRL_WIDTH_HI:CTRL_WIDTH_LO]);

    // half period follows the applied rate
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            half_reg <= half_count(START_RATE_MHZ);
        else
            half_reg <= half_count(rate_reg);
    end

    assign toggle_now = master_run && !ctrl_reg[CTRL_EXT_CLK] && osc_reg
                        && div_reg + 16'h0001 >= half_reg;
    // data is sampled two cycles late through the synchroniser, which
    // the slow clock hides: the memory holds data over a full half period
    assign rise_now = ctrl_reg[CTRL_EXT_CLK]
                      ? (master_run && ext_s2_reg && !ext_s3_reg)
                      : (toggle_now && !clk_out_reg);

    // clock divider and clock pin
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            div_reg <= 16'h0000;
            clk_out_reg <= 1'b0;
            clk_oe_reg <= 1'b0;
        end
        else
        begin
            if (toggle_now || !master_run)
                div_reg <= 16'h0000;
            else
                div_reg <= div_reg + 16'h0001;
            if (!master_run)
                clk_out_reg <= 1'b0;
            else if (ctrl_reg[CTRL_EXT_CLK])
                clk_out_reg <= ext_s2_reg;
            else if (toggle_now)
                clk_out_reg <= ~clk_out_reg;
            // slave modes leave the pin as an input, no pull-up anywhere
            clk_oe_reg <= master_run;
        end
    end

    // master-mode word assembly, width per edge from the control register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= 32'h0;
            cnt_reg <= 6'h00;
        end
        else if (!master_run)
            cnt_reg <= 6'h00;
        else if (rise_now)
        begin
            acc_reg <= shift_in(acc_reg, dat_s2_reg, bits);
            if (cnt_reg + bits >= 6'(WORD_BITS))
                cnt_reg <= 6'h00;
            else
                cnt_reg <= cnt_reg + bits;
        end
    end

    assign master_word = master_run && rise_now
                         && cnt_reg + bits >= 6'(WORD_BITS);
    assign master_data = shift_in(acc_reg, dat_s2_reg, bits);
    assign new_word = master_word || (tog_s2_reg != tog_s3_reg);
    assign new_data = master_word ? master_data : lk.word;

    // rate setting from the image; 1 MHz until one is seen
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rate_reg <= START_RATE_MHZ;
            rate_seen_reg <= 1'b0;
            word_reg <= 32'h0;
        end
        else if (begin_load)
        begin
            rate_reg <= START_RATE_MHZ;
            rate_seen_reg <= 1'b0;
        end
        else if (new_word)
        begin
            word_reg <= new_data;
            if (new_data[31:16] == RATE_MARK)
            begin
                rate_reg <= (new_data[7:0] == 8'h00)
                            ? DEFAULT_RATE_MHZ : new_data[7:0];
                rate_seen_reg <= 1'b1;
            end
        end
    end

    // oscillator and pin ownership
    assign keep_osc = ctrl_reg[CTRL_UPSET] || ctrl_reg[CTRL_TAP]
                      || ctrl_reg[CTRL_ENCRYPT]
                      || (ctrl_reg[CTRL_SUSPEND_INT] && wake_sequence);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            osc_reg <= 1'b0;
            release_reg <= 1'b0;
            scan_reg <= 1'b1;
            active_reg <= 1'b0;
        end
        else
        begin
            case (state_next)
                // the mode register only settles at this edge, so a fresh
                // load looks at the synced pins to avoid a stray cycle
                ST_LOAD:
                    osc_reg <= is_master(begin_load ? pin_s2_reg : mode_reg)
                               && !ctrl_reg[CTRL_EXT_CLK];
                ST_DONE:
                    osc_reg <= keep_osc;
                default:
                    osc_reg <= 1'b0;
            endcase
            release_reg <= state_next == ST_DONE
                           && !ctrl_reg[CTRL_KEEP_PINS];
            scan_reg <= 1'b1;
            active_reg <= state_next == ST_LOAD;
        end
    end

    // avalon slave: one wait cycle, then the answer
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
            ctrl_reg <= CTRL_RESET;
        end
        else
        begin
            wait_reg <= !((avs_read || avs_write) && wait_reg);
            if (avs_write && !wait_reg && avs_address == REG_CTRL)
                ctrl_reg <= avs_writedata[7:0];
            if (avs_read && wait_reg)
            begin
                case (avs_address)
                    REG_CTRL: rdata_reg <= {24'h0, ctrl_reg};
                    REG_STAT:
                        rdata_reg <= {26'h0, rate_seen_reg, osc_reg,
                                      state_reg == ST_DONE,
                                      state_reg == ST_LOAD, mode_reg};
                    REG_RATE: rdata_reg <= {24'h0, rate_reg};
                    REG_WORD: rdata_reg <= word_reg;
                    default: rdata_reg <= 32'h0;
                endcase
            end
        end
    end

    assign lk.rx_enable = state_reg == ST_LOAD && !is_master(mode_reg);
    assign lk.mode = mode_reg;
    assign lk.width_sel = ctrl_reg[CTRL_WIDTH_HI:CTRL_WIDTH_LO];

    cmcs_link_rx u_rx (
        .link_clock(config_clock_in),
        .rst(rst),
        .data_in(config_data_in),
        .chip_select_n(chip_select_n),
        .read_write_n(read_write_n),
        .lk(lk)
    );

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign config_clock_out = clk_out_reg;
    assign config_clock_oe = clk_oe_reg;
    assign osc_enable = osc_reg;
    assign user_pin_release = release_reg;
    assign scan_path_enable = scan_reg;
    assign config_active = active_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_mode_capture;
        begin_load |=> mode_reg == $past(pin_s2_reg);
    endproperty
    a_mode_capture: assert property (p_mode_capture)
        else $error("mode not taken from pins at load start");

    property p_mode_hold;
        (state_reg == ST_LOAD && $past(state_reg) == ST_LOAD)
            |-> $stable(mode_reg);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed during load");

    property p_master_oe;
        master_run [*2] |-> config_clock_oe;
    endproperty
    a_master_oe: assert property (p_master_oe)
        else $error("clock pin not driven in master load");

    property p_slave_oe;
        (lk.rx_enable [*2]) |-> !config_clock_oe && !config_clock_out;
    endproperty
    a_slave_oe: assert property (p_slave_oe)
        else $error("clock pin driven in slave mode");

    property p_start_rate;
        begin_load |=> rate_reg == START_RATE_MHZ && !rate_seen_reg;
    endproperty
    a_start_rate: assert property (p_start_rate)
        else $error("load did not start at the start rate");

    property p_default_rate;
        (new_word && !begin_load && new_data[31:16] == RATE_MARK
         && new_data[7:0] == 8'h00) |=> rate_reg == DEFAULT_RATE_MHZ;
    endproperty
    a_default_rate: assert property (p_default_rate)
        else $error("empty rate setting did not give the default");

    property p_half_period;
        (master_run && !ctrl_reg[CTRL_EXT_CLK] && $changed(clk_out_reg)
         && $past(master_run))
            |-> $past(div_reg) + 16'h0001 >= $past(half_reg);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("configuration clock toggled early");

    property p_osc_off;
        (state_next == ST_DONE && !keep_osc) |=> !osc_enable;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator left running after load");

    property p_wake;
        (state_reg == ST_DONE && state_next == ST_DONE
         && ctrl_reg[CTRL_SUSPEND_INT] && !ctrl_reg[CTRL_UPSET]
         && !ctrl_reg[CTRL_TAP] && !ctrl_reg[CTRL_ENCRYPT])
            |=> osc_enable == $past(wake_sequence);
    endproperty
    a_wake: assert property (p_wake)
        else $error("suspend oscillator not tied to wake sequence");

    property p_release;
        (state_reg != ST_DONE && state_next != ST_DONE)
            |=> !user_pin_release;
    endproperty
    a_release: assert property (p_release)
        else $error("clock pin released before load completed");

    property p_scan;
        scan_path_enable;
    endproperty
    a_scan: assert property (p_scan)
        else $error("boundary-scan path disabled");

    c_master_done: cover property (master_run ##[1:1000] load_complete);
    c_slave_word: cover property (lk.rx_enable && tog_s2_reg != tog_s3_reg);
    c_rate_seen: cover property ($rose(rate_seen_reg));

endmodule

// *** cmcs_top_bench.sv ***
// self-checking bench for the load-mode and clock-select block
`timescale 1ns/100ps
module cmcs_top_bench;
    import cmcs_pkg::*;
    logic clock, rst, avs_read, avs_write, avs_waitrequest, cco, coe, osc;
    logic rel, scan, act, mhi, mlo, start, done_p, wake, go, busy, lclk;
    logic cs_n, rw_n;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, pword;
    logic [15:0] din, pdata;
    logic [7:0] ecnt;
    int fail_count, n_checks, p;
    cmcs_top uut (.clock, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest,
        .load_mode_pin_hi(mhi), .load_mode_pin_lo(mlo),
        .external_master_clock(ecnt[3]), .config_clock_in(lclk),
        .config_clock_out(cco), .config_clock_oe(coe),
        .config_data_in(busy ? pdata : din), .chip_select_n(cs_n),
        .read_write_n(rw_n), .start_config(start), .load_complete(done_p),
        .wake_sequence(wake), .osc_enable(osc), .user_pin_release(rel),
        .scan_path_enable(scan), .config_active(act));
    cmcs_loader_model partner (.go, .word(pword), .link_clock(lclk),
        .data(pdata), .select_n(cs_n), .write_n(rw_n), .busy);
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) ecnt <= ecnt + 8'h01;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0)
            @(posedge clock);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic begin_load(input cmcs_mode_t m);
        @(posedge clock) {mhi, mlo} <= m;
        repeat (4) @(posedge clock);
        start <= 1'b1;
        @(posedge clock) start <= 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic end_load();
        @(posedge clock) done_p <= 1'b1;
        @(posedge clock) done_p <= 1'b0;
        repeat (2) @(negedge clock);
    endtask
    // full period of the driven clock, in system cycles
    task automatic per();
        while (cco !== 1'b0) @(negedge clock);
        while (cco !== 1'b1) @(negedge clock);
        for (p = 0; cco === 1'b1; p++) @(negedge clock);
        for (; cco !== 1'b1; p++) @(negedge clock);
    endtask
    // bit changes while the clock is low, well ahead of the 2ff sampling
    task automatic feed(input logic [63:0] w);
        for (int i = 61; i >= 0; i--)
        begin
            while (cco !== 1'b0) @(negedge clock);
            @(posedge clock) din <= {15'h0000, w[i]};
            while (cco !== 1'b1) @(negedge clock);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        fail_count++;
        summarize();
    end
    initial
    begin
        {rst, start, done_p, wake, go, mhi, mlo} = 7'h40;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {din, pword, ecnt, fail_count, n_checks} = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check({act, coe, osc, scan}, 4'h1);
        bus(1'b0, 4'h2, 32'h0);
        check(q, 32'h0);
        $display("reset test done");
        begin_load(MODE_MASTER_SERIAL);
        check({act, coe, osc}, 3'h7);
        per();
        check(p, 2 * (CLK_MHZ / (2 * START_RATE_MHZ)));
        feed({32'h0, RATE_MARK, 16'h0005});
        repeat (4) @(negedge clock);
        bus(1'b0, REG_STAT, 32'h0);
        check(q, 32'h34);
        bus(1'b0, REG_RATE, 32'h0);
        check(q, 32'h5);
        per();
        check(p, 2 * (CLK_MHZ / 10));
        // an empty rate field falls back to the default rate
        feed({32'h0, RATE_MARK, 16'h0000});
        repeat (4) @(negedge clock);
        bus(1'b0, REG_RATE, 32'h0);
        check(q, DEFAULT_RATE_MHZ);
        end_load();
        check({act, coe, osc, rel}, 4'h1);
        for (int i = 2; i < 6; i++)
        begin
            bus(1'b1, REG_CTRL, 32'h1 << i);
            repeat (2) @(negedge clock);
            check(osc, i != 4);
        end
        @(posedge clock) wake <= 1'b1;
        bus(1'b1, REG_CTRL, 32'h12);
        repeat (2) @(negedge clock);
        check({osc, rel}, 2'h2);
        @(posedge clock) wake <= 1'b0;
        $display("master test done");
        bus(1'b1, REG_CTRL, 32'h3);
        for (int m = 0; m < 3; m++)
        begin
            begin_load(2'(m));
            bus(1'b0, REG_STAT, 32'h0);
            check(q & 32'h7, 32'h4 | m);
            check({coe, osc}, {m < 2, 1'b0});
            p = 16;
            if (m < 2)
                per();
            check(p, 32'd16);
            end_load();
            check({act, rel, osc}, 3'h0);
        end
        $display("mode test done");
        bus(1'b1, REG_CTRL, 32'h0);
        begin_load(MODE_SLAVE_PARALLEL);
        check({act, coe, osc}, 3'h4);
        @(posedge clock) pword <= 32'hc3a5_5a3c;
        go <= 1'b1;
        @(negedge busy);
        repeat (10) @(posedge clock);
        go <= 1'b0;
        bus(1'b0, REG_WORD, 32'h0);
        check(q, pword);
        end_load();
        $display("slave test done");
        summarize();
    end
endmodule
